// ---- core/spm_top.sv ----
`include "spm_cfg.svh"
`default_nettype none
// Summary of operation
// RULE1 - control bits 7..5 select port 1 mode; the code takes the mode from bits 7..6 only
// RULE2 - mode 0: 8-bit synchronous, 12 or 4 clocks
// RULE3 - modes 1/3: 10/11-bit frames, timer 1 rate
// RULE4 - mode 2: 11-bit frames, 64 or 32 clocks
// RULE5 - auxiliary bit enables multiprocessor in modes 2/3
// RULE6 - port 0 mask bits select compared address bits
// RULE7 - port 1 mask bits select compared address bits
// RULE8 - cleared mask bit is excluded from comparison
// RULE9 - all-zero mask accepts every received byte
// RULE10 - multiprocessor mode needs ninth bit one
// RULE11 - ninth transmit bit sent in modes 2/3
// RULE12 - software clears transmit and receive done flags
// RULE13 - framing select makes bit 7 a framing flag
// RULE14 - address compare gates receive done at frame end
module spm_top #(
  parameter int unsigned M0_SLOW = `SPM_M0_SLOW_T,
  parameter int unsigned M0_FAST = `SPM_M0_FAST_T,
  parameter int unsigned M2_SLOW = `SPM_M2_SLOW_T,
  parameter int unsigned M2_FAST = `SPM_M2_FAST_T
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire spm_pkg::spm_bus_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic t1_ovf_i,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_n_o,
  output logic txd_o,
  input wire logic p0_rx_done_i,
  input wire logic [7:0] p0_rx_byte_i,
  output logic p0_rx_irq_o,
  output logic irq_o
);
  logic [7:0] mask0_q, mask1_q, sadr0_q, sadr1_q, rxbuf_q;
  logic [6:0] scon_q;
  logic sm0_q, fe_q, rate_doubling_bit_q, fsel_q;
  logic [`SPM_IRQ_W-1:0] ist_q, imsk_q, ev;
  logic rxd_s1_q, rxd_s2_q, rxd_s3_q;
  spm_pkg::spm_mode_t mode;
  logic sm2, ren, m0, async11;

  // mode bit 7 lives apart from the framing flag
  assign mode = spm_pkg::spm_mode_t'({sm0_q, scon_q[`SPM_B_SM1]}); // see RULE1
  assign sm2 = scon_q[`SPM_B_SM2];
  assign ren = scon_q[`SPM_B_REN];
  assign m0 = (mode == spm_pkg::SPM_M0);
  assign async11 = (mode == spm_pkg::SPM_M2) || (mode == spm_pkg::SPM_M3);

  function automatic logic hit(input logic [7:0] a);
    hit = bus_i.addr == a;
  endfunction

  // two stages before anything reads the pin
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      rxd_s3_q <= 1'b1;
    end else begin
      rxd_s1_q <= rxd_i;
      rxd_s2_q <= rxd_s1_q;
      rxd_s3_q <= rxd_s2_q;
    end
  end

  // oversampling tick, sixteen per asynchronous bit
  logic [5:0] div_q;
  logic [5:0] lim;
  logic t1half_q;
  logic tick16;
  assign lim = rate_doubling_bit_q ? 6'(M2_FAST / `SPM_OVS - 1) : 6'(M2_SLOW / `SPM_OVS - 1); // see RULE4
  // timer overflow halved unless rate doubling is set
  assign tick16 = (mode == spm_pkg::SPM_M2) ? (div_q >= lim)
                : (t1_ovf_i && (rate_doubling_bit_q || t1half_q)); // see RULE3

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      div_q <= 6'h00;
    end else if (mode != spm_pkg::SPM_M2 || div_q >= lim) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      t1half_q <= 1'b0;
    end else if (t1_ovf_i) begin
      t1half_q <= !t1half_q;
    end
  end

  // shifter shared by all transmit modes and mode 0 receive
  logic tx_busy_q, m0rx_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_bits_q, tx_ph_q, m0cnt_q, m0per;
  logic tx_start, m0rx_start, m0_tick, step, tx_done_ev, m0rx_done;
  assign m0per = sm2 ? 4'(M0_FAST) : 4'(M0_SLOW); // see RULE2
  assign m0_tick = tx_busy_q && m0 && (m0cnt_q == m0per - 4'h1);
  assign step = m0 ? m0_tick : (tick16 && tx_ph_q == 4'(`SPM_OVS - 1));
  assign tx_start = bus_i.wr && hit(`SPM_A_DBUF1) && !tx_busy_q;
  // mode 0 receive restarts while enabled and no byte is pending
  assign m0rx_start = m0 && ren && !scon_q[`SPM_B_RI] && !tx_busy_q && !tx_start;
  assign tx_done_ev = tx_busy_q && step && !m0rx_q && tx_bits_q == (m0 ? 4'h1 : 4'h2);
  assign m0rx_done = tx_busy_q && step && m0rx_q && tx_bits_q == 4'h1;

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !tx_busy_q || !m0 || m0_tick) begin
      m0cnt_q <= 4'h0;
    end else begin
      m0cnt_q <= m0cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tx_busy_q <= 1'b0;
      m0rx_q <= 1'b0;
      tx_sh_q <= '1;
      tx_bits_q <= 4'h0;
      tx_ph_q <= 4'h0;
    end else if (tx_start) begin
      tx_busy_q <= 1'b1;
      m0rx_q <= 1'b0;
      tx_ph_q <= 4'h0;
      case (mode)
        spm_pkg::SPM_M0: begin
          tx_sh_q <= {3'b111, bus_i.wdata}; // see RULE2
          tx_bits_q <= 4'd8;
        end
        spm_pkg::SPM_M1: begin
          tx_sh_q <= {2'b11, bus_i.wdata, 1'b0}; // see RULE3
          tx_bits_q <= 4'd10;
        end
        default: begin
          tx_sh_q <= {1'b1, scon_q[`SPM_B_TB8], bus_i.wdata, 1'b0}; // see RULE11
          tx_bits_q <= 4'd11;
        end
      endcase
    end else if (m0rx_start) begin
      tx_busy_q <= 1'b1;
      m0rx_q <= 1'b1;
      tx_sh_q <= '1;
      tx_bits_q <= 4'd8;
      tx_ph_q <= 4'h0;
    end else if (tx_busy_q) begin
      if (tick16 && !m0) begin
        tx_ph_q <= tx_ph_q + 4'h1;
      end
      if (step) begin
        if (m0rx_q) begin
          tx_sh_q <= {3'b111, rxd_s2_q, tx_sh_q[7:1]};
        end else begin
          tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        end
        tx_bits_q <= tx_bits_q - 4'h1;
        if (tx_bits_q == 4'h1) begin
          tx_busy_q <= 1'b0;
        end
      end
    end
  end

  // mode 0 drives data on the two-way pin and the shift clock on txd
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      txd_o <= 1'b1;
      rxd_o <= 1'b1;
      rxd_oe_n_o <= 1'b1;
    end else begin
      if (!tx_busy_q) begin
        txd_o <= 1'b1;
      end else if (m0) begin
        txd_o <= m0cnt_q >= (m0per >> 1);
      end else begin
        txd_o <= tx_sh_q[0];
      end
      rxd_o <= (m0 && tx_busy_q && !m0rx_q) ? tx_sh_q[0] : 1'b1;
      rxd_oe_n_o <= !(m0 && tx_busy_q && !m0rx_q);
    end
  end

  // asynchronous receiver, mid-bit sampling
  spm_pkg::spm_rx_st_t rx_st_q;
  logic [3:0] rx_ph_q, rx_cnt_q, nbits;
  logic [8:0] rx_sh_q;
  logic samp, rx_done_a;
  assign samp = tick16 && rx_ph_q == 4'(`SPM_OVS_MID - 1);
  assign nbits = (mode == spm_pkg::SPM_M1) ? 4'd8 : 4'd9; // see RULE3
  assign rx_done_a = (rx_st_q == spm_pkg::RX_STOP) && samp;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rx_st_q <= spm_pkg::RX_IDLE;
      rx_ph_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 9'h000;
    end else begin
      if (tick16) begin
        rx_ph_q <= rx_ph_q + 4'h1;
      end
      case (rx_st_q)
        spm_pkg::RX_IDLE: begin
          if (ren && !m0 && rxd_s3_q && !rxd_s2_q) begin
            rx_st_q <= spm_pkg::RX_START;
            rx_ph_q <= 4'h0;
          end
        end
        spm_pkg::RX_START: begin
          if (samp) begin
            // a start bit that is high again was noise
            rx_st_q <= rxd_s2_q ? spm_pkg::RX_IDLE : spm_pkg::RX_DATA;
            rx_cnt_q <= 4'h0;
          end
        end
        spm_pkg::RX_DATA: begin
          if (samp) begin
            rx_sh_q <= {rxd_s2_q, rx_sh_q[8:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == nbits - 4'h1) begin
              rx_st_q <= spm_pkg::RX_STOP;
            end
          end
        end
        spm_pkg::RX_STOP: begin
          if (samp) begin
            rx_st_q <= spm_pkg::RX_IDLE;
          end
        end
        default: rx_st_q <= spm_pkg::RX_IDLE;
      endcase
    end
  end

  // frame end: qualify the byte before raising receive done
  logic rx_done, rx9, stop_ok, addr_ok, mp, rx_accept, fe_ev, p0_hit;
  logic [7:0] rx_byte;
  always_comb begin
    rx_done = rx_done_a || m0rx_done;
    stop_ok = m0rx_done || rxd_s2_q;
    if (m0rx_done) begin
      rx_byte = {rxd_s2_q, tx_sh_q[7:1]};
      rx9 = scon_q[`SPM_B_RB8];
    end else if (mode == spm_pkg::SPM_M1) begin
      rx_byte = rx_sh_q[8:1];
      rx9 = rxd_s2_q;
    end else begin
      rx_byte = rx_sh_q[7:0];
      rx9 = rx_sh_q[8];
    end
  end
  // zero mask bits drop out, so an all-zero mask always matches
  assign addr_ok = ((rx_byte ^ sadr1_q) & mask1_q) == `SPM_RST8; // see RULE7 see RULE8 see RULE9
  assign mp = async11 && sm2; // see RULE5
  assign rx_accept = rx_done && addr_ok && !(mp && !rx9) // see RULE10 see RULE14
                  && !(mode == spm_pkg::SPM_M1 && sm2 && !stop_ok);
  assign fe_ev = rx_done_a && !rxd_s2_q && fsel_q; // see RULE13
  assign p0_hit = p0_rx_done_i
               && ((p0_rx_byte_i ^ sadr0_q) & mask0_q) == `SPM_RST8; // see RULE6 see RULE9

  // control register: hardware sets of the done flags win over writes
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      scon_q <= 7'h00;
      sm0_q <= 1'b0;
      fe_q <= 1'b0;
      rxbuf_q <= `SPM_RST8;
    end else begin
      if (bus_i.wr && hit(`SPM_A_PORT1_SERIAL_CONTROL)) begin
        scon_q <= bus_i.wdata[6:0];
        if (fsel_q) begin
          fe_q <= bus_i.wdata[`SPM_B_SM0]; // see RULE13
        end else begin
          sm0_q <= bus_i.wdata[`SPM_B_SM0]; // see RULE1
        end
      end
      if (rx_accept) begin
        rxbuf_q <= rx_byte;
        scon_q[`SPM_B_RB8] <= rx9;
        scon_q[`SPM_B_RI] <= 1'b1;
      end
      if (tx_done_ev) begin
        scon_q[`SPM_B_TI] <= 1'b1;
      end
      if (fe_ev) begin
        fe_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mask0_q <= `SPM_RST8;
      mask1_q <= `SPM_RST8;
      sadr0_q <= `SPM_RST8;
      sadr1_q <= `SPM_RST8;
      rate_doubling_bit_q <= 1'b0;
      fsel_q <= 1'b0;
      imsk_q <= '0;
    end else if (bus_i.wr) begin
      if (hit(`SPM_A_MASK0)) mask0_q <= bus_i.wdata;
      if (hit(`SPM_A_MASK1)) mask1_q <= bus_i.wdata;
      if (hit(`SPM_A_SADR0)) sadr0_q <= bus_i.wdata;
      if (hit(`SPM_A_SADR1)) sadr1_q <= bus_i.wdata;
      if (hit(`SPM_A_IMASK)) imsk_q <= bus_i.wdata[`SPM_IRQ_W-1:0];
      if (hit(`SPM_A_CFG)) begin
        rate_doubling_bit_q <= bus_i.wdata[`SPM_B_RATE_DOUBLING_BIT];
        fsel_q <= bus_i.wdata[`SPM_B_FSEL];
      end
    end
  end

  // sticky status, write one to clear, a new event wins
  assign ev = {p0_hit, fe_ev, tx_done_ev, rx_accept};
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ist_q <= '0;
      irq_o <= 1'b0;
      p0_rx_irq_o <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~((bus_i.wr && hit(`SPM_A_ISTAT))
               ? bus_i.wdata[`SPM_IRQ_W-1:0] : '0)) | ev;
      irq_o <= |(ist_q & imsk_q);
      p0_rx_irq_o <= p0_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !bus_i.rd) begin
      rdata_o <= `SPM_RST8;
    end else begin
      case (bus_i.addr)
        `SPM_A_MASK0: rdata_o <= mask0_q;
        `SPM_A_MASK1: rdata_o <= mask1_q;
        `SPM_A_PORT1_SERIAL_CONTROL: rdata_o <= {fsel_q ? fe_q : sm0_q, scon_q}; // see RULE13
        `SPM_A_DBUF1: rdata_o <= rxbuf_q;
        `SPM_A_SADR0: rdata_o <= sadr0_q;
        `SPM_A_SADR1: rdata_o <= sadr1_q;
        `SPM_A_CFG: rdata_o <= {6'h00, fsel_q, rate_doubling_bit_q};
        `SPM_A_ISTAT: rdata_o <= {4'h0, ist_q};
        `SPM_A_IMASK: rdata_o <= {4'h0, imsk_q};
        default: rdata_o <= `SPM_RST8;
      endcase
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // rate settings held still, so the divider runs undisturbed
  sequence m2_gap_s;
    (mode == spm_pkg::SPM_M2 && !rate_doubling_bit_q) [*4];
  endsequence
  sequence m0_slow_s;
    ##96 tx_busy_q ##1 !tx_busy_q;
  endsequence

  mode_write_a: assert property ( // see RULE1
    bus_i.wr && hit(`SPM_A_PORT1_SERIAL_CONTROL) && !fsel_q |=> mode[1] == $past(bus_i.wdata[7]))
    else $error("mode field not taken from write");
  m0_period_a: assert property ( // see RULE2
    tx_start && m0 && !sm2 |-> m0_slow_s)
    else $error("mode 0 byte not 96 clocks");
  frame_len_a: assert property ( // see RULE3
    tx_start && !m0 |=> tx_bits_q == ((mode == spm_pkg::SPM_M1) ? 4'd10 : 4'd11))
    else $error("async frame length wrong");
  m2_rate_a: assert property ( // see RULE4
    tick16 && mode == spm_pkg::SPM_M2 && !rate_doubling_bit_q ##1 m2_gap_s
    |-> tick16 && !$past(tick16) && !$past(tick16, 2) && !$past(tick16, 3))
    else $error("mode 2 tick spacing wrong");
  mp_gate_a: assert property ( // see RULE10
    rx_done && mp && !rx9 |-> !rx_accept ##1 !ev[`SPM_I_RX])
    else $error("multiprocessor byte accepted");
  p0_zero_a: assert property ( // see RULE9
    p0_rx_done_i && mask0_q == `SPM_RST8 |=> p0_rx_irq_o && ist_q[`SPM_I_P0])
    else $error("port 0 byte not accepted");
  p1_mask_a: assert property ( // see RULE8
    rx_done && ((rx_byte ^ sadr1_q) & mask1_q) != `SPM_RST8 |-> !rx_accept)
    else $error("masked mismatch accepted");
  ninth_tx_a: assert property ( // see RULE11
    tx_start && async11 |=> tx_sh_q[9] == $past(scon_q[`SPM_B_TB8]))
    else $error("ninth bit not loaded");
  fe_set_a: assert property ( // see RULE13
    fe_ev |=> fe_q && ist_q[`SPM_I_FE])
    else $error("framing flag not set");
  ri_set_a: assert property ( // see RULE14
    rx_accept |=> scon_q[`SPM_B_RI] && rxbuf_q == $past(rx_byte))
    else $error("receive done not raised");
endmodule
`default_nettype wire

// ---- core/spm_cfg.svh ----
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
`define SPM_A_MASK0 8'hb9
`define SPM_A_MASK1 8'hba
`define SPM_A_PORT1_SERIAL_CONTROL 8'hc0
`define SPM_A_DBUF1 8'hc1
`define SPM_A_SADR0 8'hd0
`define SPM_A_SADR1 8'hd1
`define SPM_A_CFG 8'hd2
`define SPM_A_ISTAT 8'hd3
`define SPM_A_IMASK 8'hd4
`define SPM_RST8 8'h00
`define SPM_B_RI 0
`define SPM_B_TI 1
`define SPM_B_RB8 2
`define SPM_B_TB8 3
`define SPM_B_REN 4
`define SPM_B_SM2 5
`define SPM_B_SM1 6
`define SPM_B_SM0 7
`define SPM_B_RATE_DOUBLING_BIT 0
`define SPM_B_FSEL 1
`define SPM_I_RX 0
`define SPM_I_TX 1
`define SPM_I_FE 2
`define SPM_I_P0 3
`define SPM_IRQ_W 4
`define SPM_M0_SLOW_T 12
`define SPM_M0_FAST_T 4
`define SPM_M2_SLOW_T 64
`define SPM_M2_FAST_T 32
`define SPM_OVS 16
`define SPM_OVS_MID 8
`endif

// ---- core/spm_pkg.sv ----
`default_nettype none
package spm_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spm_bus_t;
  typedef enum logic [1:0] {SPM_M0, SPM_M1, SPM_M2, SPM_M3} spm_mode_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spm_rx_st_t;
endpackage
`default_nettype wire

// ---- verification/spm_node.sv ----
`default_nettype none
module spm_node (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic line_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = 0;
  initial line_o = 1'b1;
  always @(posedge clk_i) cyc++;
  // idle mark between frames; start low, lsb first, ninth, stop
  task automatic send(input logic [7:0] b, input logic n9, stp, input int per);
    logic [10:0] f;
    f = {stp, n9, b, 1'b0};
    for (int i = 0; i < 12; i++) begin
      line_o <= (i < 11) ? f[i] : 1'b1;
      repeat (per) @(posedge clk_i);
    end
  endtask
  // steady level for the synchronous receive
  task automatic hold(input logic v);
    line_o <= v;
  endtask
  // mid-bit sampling; start bit lands in f[0]
  task automatic recv(input int per, nb, output logic [10:0] f);
    f = '0;
    @(negedge txd_i);
    repeat (per / 2) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      f[i] = txd_i;
      repeat (per) @(posedge clk_i);
    end
  endtask
  // data is taken on the rising shift clock, mid-bit where it is stable
  task automatic sync_recv(output logic [7:0] d, output int per);
    int t;
    t = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_i);
      d[i] = line_i;
      per = cyc - t;
      t = cyc;
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/spm_top_tb.sv ----
`default_nettype none
module spm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  spm_pkg::spm_bus_t bus_i = '0;
  logic t1_ovf_i = 1'b0;
  logic p0_rx_done_i = 1'b0;
  logic [7:0] p0_rx_byte_i = 8'h00;
  logic [7:0] rdata_o;
  logic rxd_w, rxd_o, rxd_oe_n_o, txd_o, node_line, p0_rx_irq_o, irq_o;
  logic [7:0] rd_v;
  logic [10:0] fr;
  int per;
  int cyc = 0;
  int bad_count = 0;
  int n_tests = 0;
  // design drives the shared data pin only while its enable is low
  assign rxd_w = rxd_oe_n_o ? node_line : rxd_o;
  spm_top u_spm_top (.clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .t1_ovf_i(t1_ovf_i), .rxd_i(rxd_w), .rxd_o(rxd_o), .rxd_oe_n_o(rxd_oe_n_o),
    .txd_o(txd_o), .p0_rx_done_i(p0_rx_done_i), .p0_rx_byte_i(p0_rx_byte_i),
    .p0_rx_irq_o(p0_rx_irq_o), .irq_o(irq_o));
  spm_node u_spm_node (.clk_i(clk_i), .txd_i(txd_o), .line_i(rxd_w), .line_o(node_line));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // timer overflow every second clock; hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    t1_ovf_i <= ~t1_ovf_i;
    if (cyc == 30000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_i <= '0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, m, exp);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_i <= '0;
    #1 chk(rdata_o & m, exp);
  endtask
  task automatic p0_case(input logic [7:0] m, b, input logic [10:0] exp);
    int hits;
    hits = 0;
    wr(8'hb9, m);
    @(posedge clk_i);
    p0_rx_done_i <= 1'b1;
    p0_rx_byte_i <= b;
    @(posedge clk_i);
    p0_rx_done_i <= 1'b0;
    repeat (4) begin
      #1 if (p0_rx_irq_o === 1'b1) hits++;
      @(posedge clk_i);
    end
    chk(11'(hits), exp);
  endtask
  // control write also clears the receive flag before each frame
  task automatic rx_case(input logic [7:0] ctl, b, input logic n9, stp, input logic [7:0] m, e);
    wr(8'hc0, ctl);
    u_spm_node.send(b, n9, stp, 32);
    repeat (4) @(posedge clk_i);
    rc(8'hc0, m, e);
  endtask
  task automatic tx_case(input logic [7:0] cfg, ctl, input int p, nb, input logic [10:0] exp);
    wr(8'hd2, cfg);
    wr(8'hc0, ctl);
    fork
      u_spm_node.recv(p, nb, fr);
      wr(8'hc1, exp[8:1]);
    join
    chk(fr, exp);
    repeat (2 * p) @(posedge clk_i);
  endtask
  task automatic sync_case(input logic [7:0] ctl, input int p);
    wr(8'hc0, ctl);
    fork
      u_spm_node.sync_recv(rd_v, per);
      wr(8'hc1, 8'ha6);
    join
    chk(rd_v, 8'ha6);
    chk(11'(per), 11'(p));
    repeat (40) @(posedge clk_i);
    chk(rxd_oe_n_o, 1'b1);
    rc(8'hc0, 8'h02, 8'h02);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    rc(8'hb9, 8'hff, 8'h00);
    rc(8'hba, 8'hff, 8'h00);
    rc(8'hc0, 8'hff, 8'h00);
    rc(8'he0, 8'hff, 8'h00);
    wr(8'hc0, 8'h6c);
    rc(8'hc0, 8'hff, 8'h6c);
    wr(8'hc0, 8'h00);
    $display("test registers done");
    wr(8'hd0, 8'h5a);
    p0_case(8'hf0, 8'h53, 1);
    p0_case(8'hf0, 8'h63, 0);
    p0_case(8'h00, 8'hc7, 1);
    p0_case(8'hff, 8'h5b, 0);
    $display("test port0 match done");
    wr(8'hd2, 8'h01);
    wr(8'hd1, 8'h42);
    rx_case(8'hb0, 8'h37, 1'b0, 1'b1, 8'h01, 8'h00);
    wr(8'hba, 8'hff);
    rx_case(8'hb0, 8'h43, 1'b1, 1'b1, 8'h01, 8'h00);
    rx_case(8'hb0, 8'h42, 1'b1, 1'b1, 8'h05, 8'h05);
    rc(8'hc1, 8'hff, 8'h42);
    wr(8'hba, 8'h0f);
    rx_case(8'hb0, 8'h92, 1'b1, 1'b1, 8'h01, 8'h01);
    wr(8'hba, 8'h00);
    wr(8'hd2, 8'h03);
    rx_case(8'h10, 8'h5e, 1'b1, 1'b0, 8'h80, 8'h80);
    $display("test receive done");
    wr(8'hd2, 8'h00);
    wr(8'hd3, 8'hff);
    u_spm_node.hold(1'b0);
    wr(8'hc0, 8'h10);
    repeat (110) @(posedge clk_i);
    rc(8'hc0, 8'h01, 8'h01);
    rc(8'hc1, 8'hff, 8'h00);
    u_spm_node.hold(1'b1);
    sync_case(8'h00, 12);
    sync_case(8'h20, 4);
    tx_case(8'h01, 8'h88, 32, 11, 11'h786);
    tx_case(8'h00, 8'h80, 64, 11, 11'h4b4);
    tx_case(8'h01, 8'hc8, 32, 11, 11'h678);
    tx_case(8'h01, 8'h40, 32, 10, 11'h34a);
    $display("test transmit done");
    rc(8'hd3, 8'h02, 8'h02);
    chk(irq_o, 1'b0);
    wr(8'hd4, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wr(8'hd3, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    rc(8'hc0, 8'h02, 8'h02);
    $display("test interrupt done");
    end_of_test();
  end
endmodule
`default_nettype wire
